// *** design/ddc_xlate_pkg.sv ***
// package: constants and types of the ddc frequency translation stage
`default_nettype none
package ddc_xlate_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int SAMPLE_W   = 16;
  localparam int PHASE_W    = 48;
  localparam int NUM_CH     = 2;
  localparam int WORD_BYTES = 6;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [15:0] PAIR_INDEX_SELECT_ADDR     = 16'h0009;
  localparam logic [15:0] SYSREF_CONTROL_LOW_ADDR    = 16'h0120;
  localparam logic [15:0] SYSREF_CONTROL_HIGH_ADDR   = 16'h0121;
  localparam logic [15:0] DOWNCONV_SYNC_CONTROL_ADDR = 16'h0300;
  localparam logic [15:0] XLATE_STATUS_ADDR          = 16'h0302;
  localparam logic [15:0] DOWNCONV0_CONTROL_ADDR     = 16'h0310;
  localparam logic [15:0] DOWNCONV1_CONTROL_ADDR     = 16'h0330;
  localparam logic [15:0] FTW_BYTE_OFS               = 16'h0006;
  localparam logic [15:0] POW_BYTE_OFS               = 16'h000d;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int MODE_LO         = 4;
  localparam int MODE_HI         = 5;
  localparam int CPLX_BIT        = 7;
  localparam int PHASE_CLEAR_BIT = 4;
  localparam int SYNC_EN_LO      = 0;
  localparam int SYNC_EN_HI      = 1;
  localparam int SYSREF_EN_BIT   = 0;
  localparam int PAIR_BIT        = 0;
  localparam logic [7:0]  REG8_RESET  = 8'h00;
  localparam logic [47:0] PHASE_RESET = 48'h0000_0000_0000;

  // ****************************************
  // oscillator and mixer constants
  // ****************************************
  localparam logic [47:0] QUARTER_STEP       = 48'h4000_0000_0000;
  localparam logic [15:0] TEST_LEVEL         = 16'h7add;
  localparam logic [15:0] COMPLEX_ATTEN      = 16'h5a82;
  localparam logic [5:0]  COS_SHIFT          = 6'h10;
  localparam logic [4:0]  QUARTER_LEN        = 5'h10;
  localparam logic [15:0] SINE_QUARTER [17]  = '{
    16'h0000, 16'h0c79, 16'h18d4, 16'h24f1, 16'h30b4, 16'h3bfe, 16'h46b4, 16'h50bd, 16'h59fe,
    16'h6261, 16'h69d1, 16'h703d, 16'h7594, 16'h79c9, 16'h7cd2, 16'h7ea7, 16'h7f44};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    IF_VARIABLE = 2'b00,
    IF_ZERO     = 2'b01,
    IF_QUARTER  = 2'b10,
    IF_TEST     = 2'b11
  } if_mode_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } iq_sample_t;

  typedef iq_sample_t [NUM_CH-1:0] iq_pair_t;

  typedef struct packed {
    logic [7:0]                      pair_sel;
    logic [7:0]                      sref_lo;
    logic [7:0]                      sref_hi;
    logic [7:0]                      sync_ctl;
    logic [NUM_CH-1:0][7:0]          ctl;
    logic [NUM_CH-1:0][PHASE_W-1:0]  freq_tuning_word;
    logic [NUM_CH-1:0][PHASE_W-1:0]  phase_offset_word;
    logic [NUM_CH-1:0][PHASE_W-1:0]  phase_accum_word;
    logic [2:0]                      sysref_sync;
    iq_pair_t [1:0]                  entry;
    logic                            head;
    logic [1:0]                      count;
    logic [7:0]                      rdata;
  } xlate_state_t;

endpackage : ddc_xlate_pkg
`default_nettype wire

// *** design/ddc_nco_mixer_translation.sv ***
// ddc frequency translation stage: oscillator pair, quadrature mixers, output buffer
//
// Behaviour
// - complex oscillator and mixer, 48-bit resolution
// - control bits 5:4 pick if mode
// - variable mode: oscillator tunes, mixers run
// - zero if: mixers bypassed, oscillator stopped
// - quarter mode: cheap shift by fs/4
// - test mode forces 0.9599 full scale input
// - tuning word is signed 48-bit fraction
// - real mixdown loss left for gain stage
// - complex products attenuated 3.01 dB
// - phase offset added to accumulator phase
// - offset writes leave accumulator alone
// - accumulator resets zero, steps by tuning word, by fs/4 in quarter mode
// - clear bit high then low clears accumulators
// - armed sysref event clears all accumulators
// - real uses two products, complex four
// - control bit 7 picks real or complex
// - pair index gates per-channel writes
// - output always feeds first half-band filter
`timescale 1ns/10ps
`default_nettype none
module ddc_nco_mixer_translation
  import ddc_xlate_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  output logic      [7:0]  reg_rdata_out,
  // sync pin
  input  wire logic        sysref_in,
  // adc sample stream
  input  wire iq_sample_t  in_sample_in,
  input  wire logic        in_valid_in,
  output logic             in_ready_out,
  // stream to first half-band filter
  output iq_pair_t         hb1_data_out,
  output logic             hb1_valid_out,
  input  wire logic        hb1_ready_in
);

  // ****************************************
  // state and shared terms
  // ****************************************
  xlate_state_t state_reg;
  xlate_state_t state_next;
  logic         sysref_armed;
  logic         sysref_event;
  logic         push;
  logic         pop;
  logic         clear;
  logic         wr_idx;

  assign sysref_armed = state_reg.sref_lo[SYSREF_EN_BIT]
                        && (|state_reg.sync_ctl[SYNC_EN_HI:SYNC_EN_LO]);
  assign sysref_event = state_reg.sysref_sync[1] && !state_reg.sysref_sync[2] && sysref_armed;
  assign clear        = state_reg.sync_ctl[PHASE_CLEAR_BIT] || sysref_event;
  assign in_ready_out = state_reg.count != BUF_DEPTH;
  assign push         = in_valid_in && in_ready_out;
  assign pop          = hb1_valid_out && hb1_ready_in;
  assign wr_idx       = state_reg.head ^ state_reg.count[0];

  assign hb1_valid_out = state_reg.count != 2'h0;
  assign hb1_data_out  = state_reg.entry[state_reg.head];
  assign reg_rdata_out = state_reg.rdata;

  // ****************************************
  // quarter-wave sine lookup
  // ****************************************
  function automatic logic signed [15:0] sine_of(input logic [5:0] a);
    logic [4:0]  idx;
    logic [15:0] mag;
    idx = a[4] ? 5'(QUARTER_LEN - {1'b0, a[3:0]}) : {1'b0, a[3:0]};
    mag = SINE_QUARTER[idx];
    return a[5] ? -$signed(mag) : $signed(mag);
  endfunction : sine_of

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    if_mode_t                 mode;
    logic                     cplx;
    logic signed [15:0]       xi;
    logic signed [15:0]       xq;
    logic signed [15:0]       cs;
    logic signed [15:0]       sn;
    logic [47:0]              ph;
    logic signed [31:0]       p_ic;
    logic signed [31:0]       p_qs;
    logic signed [31:0]       p_qc;
    logic signed [31:0]       p_is;
    logic signed [32:0]       sum_i;
    logic signed [32:0]       sum_q;
    logic signed [49:0]       att_i;
    logic signed [49:0]       att_q;
    iq_pair_t                 mixed;
    mode       = IF_VARIABLE;
    cplx       = 1'b0;
    xi         = '0;
    xq         = '0;
    cs         = '0;
    sn         = '0;
    ph         = '0;
    p_ic       = '0;
    p_qs       = '0;
    p_qc       = '0;
    p_is       = '0;
    sum_i      = '0;
    sum_q      = '0;
    att_i      = '0;
    att_q      = '0;
    mixed      = '0;
    state_next = state_reg;
    state_next.sysref_sync = {state_reg.sysref_sync[1:0], sysref_in};

    for (int c = 0; c < NUM_CH; c++)
    begin
      mode = if_mode_t'(state_reg.ctl[c][MODE_HI:MODE_LO]);
      cplx = state_reg.ctl[c][CPLX_BIT];
      xi   = (mode == IF_TEST) ? $signed(TEST_LEVEL) : in_sample_in.i;
      xq   = (mode == IF_TEST || !cplx) ? 16'sh0000 : in_sample_in.q;
      ph   = state_reg.phase_accum_word[c] + state_reg.phase_offset_word[c];
      cs   = sine_of(6'(ph[47:42] + COS_SHIFT));
      sn   = sine_of(ph[47:42]);
      p_ic  = xi * cs;
      p_is  = xi * sn;
      p_qc  = cplx ? xq * cs : 32'sh0;
      p_qs  = cplx ? xq * sn : 32'sh0;
      sum_i = 33'(p_ic) + 33'(p_qs);
      sum_q = 33'(p_qc) - 33'(p_is);
      att_i = sum_i * $signed({1'b0, COMPLEX_ATTEN});
      att_q = sum_q * $signed({1'b0, COMPLEX_ATTEN});
      case (mode)
        IF_ZERO:
        begin
          mixed[c].i = xi;
          mixed[c].q = xq;
        end
        IF_QUARTER:
        begin
          case (ph[47:46])
            2'h0:
            begin
              mixed[c].i = xi;
              mixed[c].q = xq;
            end
            2'h1:
            begin
              mixed[c].i = xq;
              mixed[c].q = -xi;
            end
            2'h2:
            begin
              mixed[c].i = -xi;
              mixed[c].q = -xq;
            end
            default:
            begin
              mixed[c].i = -xq;
              mixed[c].q = xi;
            end
          endcase
        end
        default:
        begin
          mixed[c].i = cplx ? att_i[45:30] : sum_i[30:15];
          mixed[c].q = cplx ? att_q[45:30] : sum_q[30:15];
        end
      endcase

      if (clear)
      begin
        state_next.phase_accum_word[c] = PHASE_RESET;
      end
      else if (push && mode == IF_QUARTER)
      begin
        state_next.phase_accum_word[c] = state_reg.phase_accum_word[c] + QUARTER_STEP;
      end
      else if (push && mode != IF_ZERO)
      begin
        state_next.phase_accum_word[c] = state_reg.phase_accum_word[c] + state_reg.freq_tuning_word[c];
      end
    end

    // ****************************************
    // two-entry output buffer
    // ****************************************
    if (push)
    begin
      state_next.entry[wr_idx] = mixed;
    end
    if (pop)
    begin
      state_next.head = ~state_reg.head;
    end
    state_next.count = 2'(state_reg.count + {1'b0, push} - {1'b0, pop});

    // ****************************************
    // register writes
    // ****************************************
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        PAIR_INDEX_SELECT_ADDR:     state_next.pair_sel = reg_wdata_in;
        SYSREF_CONTROL_LOW_ADDR:    state_next.sref_lo  = reg_wdata_in;
        SYSREF_CONTROL_HIGH_ADDR:   state_next.sref_hi  = reg_wdata_in;
        DOWNCONV_SYNC_CONTROL_ADDR: state_next.sync_ctl = reg_wdata_in;
        default:                    state_next.pair_sel = state_reg.pair_sel;
      endcase
      if (state_reg.pair_sel[PAIR_BIT])
      begin
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (reg_addr_in == (c == 0 ? DOWNCONV0_CONTROL_ADDR : DOWNCONV1_CONTROL_ADDR))
          begin
            state_next.ctl[c] = reg_wdata_in;
          end
          for (int b = 0; b < WORD_BYTES; b++)
          begin
            if (reg_addr_in == 16'((c == 0 ? DOWNCONV0_CONTROL_ADDR : DOWNCONV1_CONTROL_ADDR)
                                   + FTW_BYTE_OFS + 16'(b)))
            begin
              state_next.freq_tuning_word[c][b*8 +: 8] = reg_wdata_in;
            end
            if (reg_addr_in == 16'((c == 0 ? DOWNCONV0_CONTROL_ADDR : DOWNCONV1_CONTROL_ADDR)
                                   + POW_BYTE_OFS + 16'(b)))
            begin
              state_next.phase_offset_word[c][b*8 +: 8] = reg_wdata_in;
            end
          end
        end
      end
    end

    // ****************************************
    // register read data
    // ****************************************
    case (reg_addr_in)
      PAIR_INDEX_SELECT_ADDR:     state_next.rdata = state_reg.pair_sel;
      SYSREF_CONTROL_LOW_ADDR:    state_next.rdata = state_reg.sref_lo;
      SYSREF_CONTROL_HIGH_ADDR:   state_next.rdata = state_reg.sref_hi;
      DOWNCONV_SYNC_CONTROL_ADDR: state_next.rdata = state_reg.sync_ctl;
      XLATE_STATUS_ADDR:          state_next.rdata = {state_reg.count, 5'h00, sysref_armed};
      DOWNCONV0_CONTROL_ADDR:     state_next.rdata = state_reg.ctl[0];
      DOWNCONV1_CONTROL_ADDR:     state_next.rdata = state_reg.ctl[1];
      default:                    state_next.rdata = REG8_RESET;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_clear_pulse;
    state_reg.sync_ctl[PHASE_CLEAR_BIT] ##1 !state_reg.sync_ctl[PHASE_CLEAR_BIT];
  endsequence

  sequence s_sysref_rise;
    sysref_event;
  endsequence

  property p_soft_clear;
    s_clear_pulse |-> state_reg.phase_accum_word[0] == PHASE_RESET && state_reg.phase_accum_word[1] == PHASE_RESET;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft clear left phase");

  property p_sysref_clear;
    s_sysref_rise |=> state_reg.phase_accum_word[0] == PHASE_RESET && state_reg.phase_accum_word[1] == PHASE_RESET;
  endproperty
  a_sysref_clear: assert property (p_sysref_clear) else $error("sysref left phase");

  property p_var_step;
    push && !clear && state_reg.ctl[0][MODE_HI:MODE_LO] == IF_VARIABLE
      |=> state_reg.phase_accum_word[0] == 48'($past(state_reg.phase_accum_word[0]) + $past(state_reg.freq_tuning_word[0]));
  endproperty
  a_var_step: assert property (p_var_step) else $error("phase step wrong");

  property p_quarter_step;
    push && !clear && state_reg.ctl[0][MODE_HI:MODE_LO] == IF_QUARTER
      |=> state_reg.phase_accum_word[0] == 48'($past(state_reg.phase_accum_word[0]) + QUARTER_STEP);
  endproperty
  a_quarter_step: assert property (p_quarter_step) else $error("quarter step wrong");

  property p_zero_hold;
    push && !clear && state_reg.ctl[0][MODE_HI:MODE_LO] == IF_ZERO |=> $stable(state_reg.phase_accum_word[0]);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero if moved phase");

  property p_zero_pass;
    push && state_reg.count == 2'h0 && state_reg.ctl[0][MODE_HI:MODE_LO] == IF_ZERO
      |=> hb1_valid_out && hb1_data_out[0].i == $past(in_sample_in.i);
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("zero if altered data");

  property p_pow_quiet;
    reg_wr_in && 16'(reg_addr_in - DOWNCONV0_CONTROL_ADDR - POW_BYTE_OFS) < 16'(WORD_BYTES)
      && !push && !clear |=> $stable(state_reg.phase_accum_word[0]);
  endproperty
  a_pow_quiet: assert property (p_pow_quiet) else $error("offset write moved phase");

  property p_pair_gate;
    reg_wr_in && reg_addr_in == DOWNCONV0_CONTROL_ADDR && !state_reg.pair_sel[PAIR_BIT]
      |=> $stable(state_reg.ctl[0]);
  endproperty
  a_pair_gate: assert property (p_pair_gate) else $error("unselected pair written");

  property p_full_stall;
    state_reg.count == BUF_DEPTH |-> !in_ready_out ##1 state_reg.count != 2'h3;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("buffer overfilled");

  property p_out_hold;
    hb1_valid_out && !hb1_ready_in |=> hb1_valid_out && $stable(hb1_data_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled output changed");

endmodule : ddc_nco_mixer_translation
`default_nettype wire

// *** tb/hb1_sink_model.sv ***
// first half-band filter input model: takes words, stalls on command
`timescale 1ns/10ps
`default_nettype none
module hb1_sink_model
  import ddc_xlate_pkg::*;
(
  // clock and reset
  input  wire logic     clk_in,
  input  wire logic     sys_rst_in,
  // stall control from bench
  input  wire logic     stall_in,
  // stream from translation stage
  input  wire iq_pair_t hb1_data_in,
  input  wire logic     hb1_valid_in,
  output logic          hb1_ready_out
);
  iq_pair_t got [$];

  // ****************************************
  // accept words
  // ****************************************
  // filter takes output unless stalled or in reset
  assign hb1_ready_out = !stall_in && !sys_rst_in;

  always @(posedge clk_in)
  begin
    if (!sys_rst_in && hb1_valid_in && hb1_ready_out)
    begin
      got.push_back(hb1_data_in);
    end
  end
endmodule : hb1_sink_model
`default_nettype wire

// *** tb/ddc_nco_mixer_translation_test.sv ***
// self-checking bench of the ddc frequency translation stage
`timescale 1ns/10ps
`default_nettype none
module ddc_nco_mixer_translation_test;
  import ddc_xlate_pkg::*;
  typedef struct {
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [7:0]  p0;
    logic [31:0] s;
    logic [31:0] e0;
    logic [31:0] e1;
  } row_t;
  logic        clk_in;
  logic        sys_rst_in;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic [7:0]  reg_rdata_out;
  logic        sysref;
  iq_sample_t  in_sample;
  logic        in_valid;
  logic        in_ready_out;
  iq_pair_t    hb1_data_out;
  logic        hb1_valid_out;
  logic        hb1_ready;
  logic        stall;
  int          failures;
  int          num_checks;
  row_t        rows [6] = '{
    '{8'h10, 8'h90, 8'h00, 32'h1234_5678, 32'h1234_0000, 32'h1234_5678},
    '{8'h20, 8'ha0, 8'h40, 32'h2000_1000, 32'h0000_e000, 32'h2000_1000},
    '{8'ha0, 8'h10, 8'h40, 32'h2000_1000, 32'h1000_e000, 32'h2000_0000},
    '{8'h20, 8'h20, 8'h80, 32'h2000_1000, 32'he000_0000, 32'h2000_0000},
    '{8'h30, 8'h00, 8'h00, 32'h4000_0000, 32'h7a28_0000, 32'h3fa2_0000},
    '{8'h80, 8'hb0, 8'h00, 32'h4000_2000, 32'h2cfe_167f, 32'h5660_0000}};
  logic [31:0] var_exp [4] = '{32'h3fa2_0000, 32'h0000_3fa2, 32'hc05e_0000, 32'h0000_c05e};
  logic [31:0] stl_exp [3] = '{32'h2000_0000, 32'h0000_e000, 32'he000_0000};

  ddc_nco_mixer_translation uut (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .reg_addr_in   (reg_addr),
    .reg_wdata_in  (reg_wdata),
    .reg_wr_in     (reg_wr),
    .reg_rdata_out (reg_rdata_out),
    .sysref_in     (sysref),
    .in_sample_in  (in_sample),
    .in_valid_in   (in_valid),
    .in_ready_out  (in_ready_out),
    .hb1_data_out  (hb1_data_out),
    .hb1_valid_out (hb1_valid_out),
    .hb1_ready_in  (hb1_ready)
  );

  hb1_sink_model sink (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .stall_in      (stall),
    .hb1_data_in   (hb1_data_out),
    .hb1_valid_in  (hb1_valid_out),
    .hb1_ready_out (hb1_ready)
  );

  // ****************************************
  // clock, watchdog and helpers
  // ****************************************
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  initial
  begin
    #400000;
    failures++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_in);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_in);
    reg_addr = a;
    @(negedge clk_in);
    chk(64'(reg_rdata_out), 64'(e));
  endtask : rd

  task automatic osc_clear();
    wr(DOWNCONV_SYNC_CONTROL_ADDR, 8'h10);
    wr(DOWNCONV_SYNC_CONTROL_ADDR, 8'h00);
  endtask : osc_clear

  task automatic push(input logic [31:0] s);
    int n;
    n = 0;
    @(negedge clk_in);
    in_sample = s;
    in_valid  = 1'b1;
    while (!in_ready_out && n < 50)
    begin
      @(negedge clk_in);
      n++;
    end
    if (!in_ready_out)
      failures++;
    @(posedge clk_in);
  endtask : push

  task automatic idle();
    @(negedge clk_in);
    in_valid = 1'b0;
  endtask : idle

  task automatic pop_chk(input logic [31:0] e0, input logic [31:0] e1);
    int n;
    n = 0;
    while (sink.got.size() == 0 && n < 50)
    begin
      @(negedge clk_in);
      n++;
    end
    if (sink.got.size() == 0)
      failures++;
    else
      chk(64'(sink.got.pop_front()), {e1, e0});
  endtask : pop_chk

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_rst_in = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    sysref = 1'b0;
    in_sample = 32'h0000_0000;
    in_valid = 1'b0;
    stall = 1'b0;
    failures = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk(64'(hb1_valid_out), 64'h0);
    chk(64'(in_ready_out), 64'h1);
    rd(DOWNCONV0_CONTROL_ADDR, 8'h00);
    rd(DOWNCONV_SYNC_CONTROL_ADDR, 8'h00);
    wr(DOWNCONV0_CONTROL_ADDR, 8'h10);
    rd(DOWNCONV0_CONTROL_ADDR, 8'h00);
    wr(PAIR_INDEX_SELECT_ADDR, 8'h01);
    wr(16'h0200, 8'h5a);
    rd(16'h0200, 8'h00);
    wr(XLATE_STATUS_ADDR, 8'hff);
    rd(XLATE_STATUS_ADDR, 8'h00);
    foreach (rows[k])
    begin
      wr(DOWNCONV0_CONTROL_ADDR, rows[k].c0);
      wr(DOWNCONV1_CONTROL_ADDR, rows[k].c1);
      rd(DOWNCONV1_CONTROL_ADDR, rows[k].c1);
      wr(DOWNCONV0_CONTROL_ADDR + POW_BYTE_OFS + 16'h0005, rows[k].p0);
      osc_clear();
      push(rows[k].s);
      idle();
      pop_chk(rows[k].e0, rows[k].e1);
    end
    for (int b = 0; b < WORD_BYTES; b++)
      wr(DOWNCONV0_CONTROL_ADDR + FTW_BYTE_OFS + 16'(b), (b == 5) ? 8'hc0 : 8'h00);
    wr(DOWNCONV0_CONTROL_ADDR, 8'h00);
    wr(DOWNCONV1_CONTROL_ADDR, 8'h10);
    osc_clear();
    for (int k = 0; k < 4; k++)
      push(32'h4000_0000);
    idle();
    for (int k = 0; k < 4; k++)
      pop_chk(var_exp[k], 32'h4000_0000);
    wr(DOWNCONV0_CONTROL_ADDR, 8'h20);
    osc_clear();
    stall = 1'b1;
    push(32'h2000_0000);
    push(32'h2000_0000);
    @(negedge clk_in);
    chk(64'(in_ready_out), 64'h0);
    rd(XLATE_STATUS_ADDR, 8'h80);
    chk(64'(hb1_valid_out), 64'h1);
    @(negedge clk_in);
    stall = 1'b0;
    push(32'h2000_0000);
    idle();
    for (int k = 0; k < 3; k++)
      pop_chk(stl_exp[k], 32'h2000_0000);
    wr(DOWNCONV0_CONTROL_ADDR + POW_BYTE_OFS + 16'h0005, 8'h40);
    push(32'h2000_0000);
    idle();
    pop_chk(32'h2000_0000, 32'h2000_0000);
    wr(DOWNCONV0_CONTROL_ADDR + POW_BYTE_OFS + 16'h0005, 8'h00);
    push(32'h2000_0000);
    idle();
    pop_chk(32'h2000_0000, 32'h2000_0000);
    osc_clear();
    push(32'h2000_0000);
    idle();
    pop_chk(32'h2000_0000, 32'h2000_0000);
    push(32'h2000_0000);
    idle();
    pop_chk(32'h0000_e000, 32'h2000_0000);
    wr(SYSREF_CONTROL_LOW_ADDR, 8'h01);
    wr(DOWNCONV_SYNC_CONTROL_ADDR, 8'h01);
    rd(XLATE_STATUS_ADDR, 8'h01);
    @(negedge clk_in);
    sysref = 1'b1;
    repeat (3) @(negedge clk_in);
    sysref = 1'b0;
    repeat (5) @(negedge clk_in);
    push(32'h2000_0000);
    idle();
    pop_chk(32'h2000_0000, 32'h2000_0000);
    tally_and_finish();
  end
endmodule : ddc_nco_mixer_translation_test
`default_nettype wire
